// *** hdl/asq_sequencer.sv ***
// asq_sequencer: top of the converter scan / trigger sequencer
// assumes: analog core answers a convert request with one done pulse,
// hardware trigger is a one-cycle pulse synchronous to clock
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"

// Summary of operation
// - setting enable from stop enters standby, no conversion starts
// - software scan start converts four channels, slot zero through three
// - each finished in-range conversion stores result and pulses done interrupt
// - sequential mode advances to next conversion without new start
// - software scan one-shot clears start after fourth channel, standby
// - writing start one during conversion aborts and restarts, scan at slot zero
// - any channel-select write during conversion aborts and restarts conversion
// - software modes ignore hardware triggers during conversion
// - clearing start during conversion aborts and returns to standby
// - clearing enable in standby stops; start ignored while enable zero
// - software one-shot ignores hardware trigger in standby
// - hardware mode start enters trigger standby, repeated starts convert nothing
// - trigger with start set converts channel named by select register
// - hardware sequential mode starts next conversion immediately
// - hardware one-shot keeps start set and waits for next trigger
// - trigger during hardware-mode conversion aborts and restarts
// - hardware mode start clear stops conversion, stays enabled standby
// - hardware triggers ignored while start is zero
// - sixteen-bit result word holds ten-bit value; eight-bit byte form
// - out-of-range result is not stored and raises no interrupt
// - start bit sits at bit seven of mode register zero
module asq_sequencer #(
    parameter int CHAN_W     = 5,
    parameter int SCAN_SLOTS = 4,
    parameter int RESULT_W   = 10
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // apb register port
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ASQ_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // analog core
    output logic                        core_convert_req,
    output logic      [CHAN_W-1:0]      core_channel,
    output logic                        core_abort,
    input  wire logic                   core_done,
    input  wire logic [RESULT_W-1:0]    core_sar,
    input  wire logic                   core_in_range,
    // trigger and interrupt
    input  wire logic                   hw_trigger,
    output logic                        conversion_done_irq
);
    localparam int SLOT_W = $clog2(SCAN_SLOTS);

    // refuse shapes the logic cannot serve
    if (SCAN_SLOTS < 2 || (SCAN_SLOTS & (SCAN_SLOTS - 1)) != 0) begin : g_chk_slots
        $error("scan slot count must be a power of two of at least two");
    end
    if (RESULT_W < 8 || RESULT_W > 16 || CHAN_W < 1 || CHAN_W > 8) begin : g_chk_widths
        $error("result width must be 8..16 and channel width 1..8");
    end

    localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(SCAN_SLOTS - 1);

    // scan slot n converts the selected channel plus n
    function automatic logic [CHAN_W-1:0] slot_channel(
        input logic [CHAN_W-1:0] base,
        input logic [SLOT_W-1:0] slot_no,
        input logic              scanning
    );
        return scanning ? base + CHAN_W'(slot_no) : base;
    endfunction

    asq_link_if #(.RESULT_W(RESULT_W)) link ();

    asq_apb_port u_port (
        .clock   (clock),
        .reset_n (reset_n),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .link    (link.bus)
    );

    asq_result_store #(.RESULT_W(RESULT_W)) u_result (
        .clock   (clock),
        .reset_n (reset_n),
        .link    (link.res)
    );

    // software-visible control state
    asq_pkg::asq_state_type state;
    asq_pkg::asq_state_type next_state;
    logic                   converter_power_enable;
    logic                   conversion_start_bit;
    logic                   mode_oneshot;
    logic                   mode_hw_trigger;
    logic                   mode_scan;
    logic [CHAN_W-1:0]      input_channel_select;
    logic [SLOT_W-1:0]      slot;
    logic [15:0]            stab_count;
    logic                   stable;

    // next values
    logic                   next_enable;
    logic                   next_start;
    logic [SLOT_W-1:0]      next_slot;
    logic [CHAN_W-1:0]      next_select;
    logic                   abort_now;
    logic                   store_now;
    logic                   restart;

    // decoded accesses
    logic                   mode_wr;
    logic                   sel_wr;
    logic                   busy;
    logic                   scan_active;
    logic                   hw_fire;

    assign mode_wr = link.acc && link.wr && link.addr == `ASQ_OFS_MODE;
    assign sel_wr  = link.acc && link.wr && link.addr == `ASQ_OFS_SEL;
    assign busy    = state == asq_pkg::ASQ_LAUNCH || state == asq_pkg::ASQ_CONVERT;

    // scanning only applies to the software trigger modes here
    assign scan_active = mode_scan && !mode_hw_trigger;

    // triggers count only in hardware mode with start set
    assign hw_fire = hw_trigger && mode_hw_trigger && conversion_start_bit;

    assign next_select = sel_wr ? link.wdata[CHAN_W-1:0] : input_channel_select;

    // sequencing decisions; a software write beats the trigger and core done
    always_comb begin
        next_state  = state;
        next_enable = converter_power_enable;
        next_start  = conversion_start_bit;
        next_slot   = slot;
        abort_now   = 1'b0;
        store_now   = 1'b0;
        restart     = 1'b0;
        if (mode_wr) begin
            next_enable = link.wdata[`ASQ_BIT_ENABLE];
            // start cannot be set while enable is off
            next_start  = link.wdata[`ASQ_BIT_START] & link.wdata[`ASQ_BIT_ENABLE];
            if (!link.wdata[`ASQ_BIT_ENABLE]) begin
                next_state = asq_pkg::ASQ_STOP;
                abort_now  = busy;
            end else if (!link.wdata[`ASQ_BIT_START]) begin
                // stays enabled; from stop this is the standby entry
                next_state = asq_pkg::ASQ_STANDBY;
                abort_now  = busy;
            end else if (link.wdata[`ASQ_BIT_HWTRIG]) begin
                if (busy) begin
                    abort_now = 1'b1;
                    restart   = 1'b1;
                end else begin
                    next_state = asq_pkg::ASQ_HW_WAIT;
                end
            end else begin
                abort_now = busy;
                restart   = 1'b1;
            end
        end else if (sel_wr) begin
            if (busy) begin
                abort_now = 1'b1;
                restart   = 1'b1;
            end
        end else if (hw_fire) begin
            if (busy) begin
                abort_now = 1'b1;
                restart   = 1'b1;
            end else if (state == asq_pkg::ASQ_HW_WAIT) begin
                restart = 1'b1;
            end
        end else if (state == asq_pkg::ASQ_LAUNCH) begin
            next_state = asq_pkg::ASQ_CONVERT;
        end else if (state == asq_pkg::ASQ_CONVERT && core_done) begin
            // results outside the acceptance range leave no trace
            store_now = core_in_range;
            if (scan_active && slot != LAST_SLOT) begin
                next_slot  = slot + 1'b1;
                next_state = asq_pkg::ASQ_LAUNCH;
            end else if (mode_oneshot && mode_hw_trigger) begin
                next_state = asq_pkg::ASQ_HW_WAIT;
            end else if (mode_oneshot) begin
                next_start = 1'b0;
                next_state = asq_pkg::ASQ_STANDBY;
            end else begin
                next_slot  = '0;
                next_state = asq_pkg::ASQ_LAUNCH;
            end
        end
        // every restart begins again at scan slot zero
        if (restart) begin
            next_state = asq_pkg::ASQ_LAUNCH;
            next_slot  = '0;
        end
    end

    // sequencer state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= asq_pkg::ASQ_STOP;
        end else begin
            state <= next_state;
        end
    end

    // enable and start bits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            converter_power_enable <= 1'b0;
            conversion_start_bit   <= 1'b0;
        end else begin
            converter_power_enable <= next_enable;
            conversion_start_bit   <= next_start;
        end
    end

    // mode fields take effect with the same write as the start bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_oneshot    <= 1'b0;
            mode_hw_trigger <= 1'b0;
            mode_scan       <= 1'b0;
        end else if (mode_wr) begin
            mode_oneshot    <= link.wdata[`ASQ_BIT_ONESHOT];
            mode_hw_trigger <= link.wdata[`ASQ_BIT_HWTRIG];
            mode_scan       <= link.wdata[`ASQ_BIT_SCAN];
        end
    end

    // channel select register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_channel_select <= '0;
        end else begin
            input_channel_select <= next_select;
        end
    end

    // scan slot position
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            slot <= '0;
        end else begin
            slot <= next_slot;
        end
    end

    // channel is latched on entry to launch so it is steady for the core
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_channel <= '0;
        end else if (next_state == asq_pkg::ASQ_LAUNCH) begin
            core_channel <= slot_channel(next_select, next_slot, scan_active);
        end
    end

    // launch lasts one cycle unless a restart lands in it, which keeps the request high one more cycle
    assign core_convert_req = state == asq_pkg::ASQ_LAUNCH;

    // abort strobe; the core drops its partial result on it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_abort <= 1'b0;
        end else begin
            core_abort <= abort_now;
        end
    end

    // interrupt pulse rises one edge before the result registers update
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            conversion_done_irq <= 1'b0;
        end else begin
            conversion_done_irq <= store_now;
        end
    end

    // result store gets the value one edge later, together with the irq
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            link.store <= 1'b0;
            link.sar   <= '0;
        end else begin
            link.store <= store_now;
            link.sar   <= core_sar;
        end
    end

    // stabilisation timer after enable; purely informative to software,
    // the sequencer does not hold off a start on it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stab_count <= '0;
            stable     <= 1'b0;
        end else if (!converter_power_enable) begin
            stab_count <= '0;
            stable     <= 1'b0;
        end else if (stab_count == 16'(`ASQ_STAB_CYCLES - 1)) begin
            stable     <= 1'b1;
        end else begin
            stab_count <= stab_count + 16'h0001;
        end
    end

    // register read mux and unmapped detect
    always_comb begin
        link.rdata = 32'h0000_0000;
        link.err   = 1'b0;
        case (link.addr)
            `ASQ_OFS_MODE: begin
                link.rdata[`ASQ_BIT_ENABLE]  = converter_power_enable;
                link.rdata[`ASQ_BIT_ONESHOT] = mode_oneshot;
                link.rdata[`ASQ_BIT_HWTRIG]  = mode_hw_trigger;
                link.rdata[`ASQ_BIT_SCAN]    = mode_scan;
                link.rdata[`ASQ_BIT_START]   = conversion_start_bit;
            end
            `ASQ_OFS_SEL: begin
                link.rdata[CHAN_W-1:0] = input_channel_select;
            end
            `ASQ_OFS_RES: begin
                link.rdata[15:0] = link.res_word;
            end
            `ASQ_OFS_RESH: begin
                link.rdata[7:0] = link.res_high;
            end
            `ASQ_OFS_STAT: begin
                link.rdata[0]         = stable;
                link.rdata[1]         = busy;
                link.rdata[6:4]       = state;
                link.rdata[8 +: SLOT_W] = slot;
            end
            default: begin
                link.err = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire

// *** hdl/asq_params.svh ***
// asq_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the sequencer design files
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH

// register byte offsets on the apb slave
`define ASQ_ADDR_W        8
`define ASQ_OFS_MODE      8'h00
`define ASQ_OFS_SEL       8'h04
`define ASQ_OFS_RES       8'h08
`define ASQ_OFS_RESH      8'h0C
`define ASQ_OFS_STAT      8'h10

// fields of converter_mode_reg_zero
`define ASQ_BIT_ENABLE    0
`define ASQ_BIT_ONESHOT   1
`define ASQ_BIT_HWTRIG    2
`define ASQ_BIT_SCAN      3
`define ASQ_BIT_START     7

// result alignment: left-justified in the 16-bit word
`define ASQ_RES_SHIFT     6
`define ASQ_RES_RESET     16'h0000
`define ASQ_RESH_RESET    8'h00

// enable stabilisation time, software's to honour; shown as a status flag
`define ASQ_CLK_PERIOD_NS 4
`define ASQ_STAB_TIME_NS  1000
`define ASQ_STAB_CYCLES   ((`ASQ_STAB_TIME_NS + `ASQ_CLK_PERIOD_NS - 1) / `ASQ_CLK_PERIOD_NS)

`endif

// *** hdl/asq_pkg.sv ***
// asq_pkg: types shared by the scan/trigger sequencer files
// assumes: nothing beyond a systemverilog compiler
package asq_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ASQ_STOP,
        ASQ_STANDBY,
        ASQ_HW_WAIT,
        ASQ_LAUNCH,
        ASQ_CONVERT
    } asq_state_type;

endpackage

// *** hdl/asq_link_if.sv ***
// asq_link_if: internal carrier between bus port, sequencer and result store
// assumes: one clock domain; all members driven by exactly one modport
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"
interface asq_link_if #(parameter int RESULT_W = 10);
    // decoded bus access
    logic                   acc;
    logic                   wr;
    logic [`ASQ_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic [31:0]            rdata;
    logic                   err;
    // result capture
    logic                   store;
    logic [RESULT_W-1:0]    sar;
    logic [15:0]            res_word;
    logic [7:0]             res_high;

    modport bus (output acc, wr, addr, wdata, input rdata, err);
    modport seq (input acc, wr, addr, wdata, res_word, res_high,
                 output rdata, err, store, sar);
    modport res (input store, sar, output res_word, res_high);
endinterface
`default_nettype wire

// *** hdl/asq_apb_port.sv ***
// asq_apb_port: apb slave front end, no wait states
// assumes: read data and error from the sequencer are combinational
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"
module asq_apb_port (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // apb
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ASQ_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // internal side
    asq_link_if.bus                     link
);
    // access phase is the commit edge; always ready
    assign pready     = 1'b1;
    assign link.acc   = psel & penable;
    assign link.wr    = pwrite;
    assign link.addr  = paddr;
    assign link.wdata = pwdata;

    // read data and error sampled in setup so they come from flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : link.rdata;
            pslverr <= link.err;
        end
    end
endmodule
`default_nettype wire

// *** hdl/asq_result_store.sv ***
// asq_result_store: full and byte-wide conversion result registers
// assumes: store is a one-cycle pulse with sar valid in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"
module asq_result_store #(
    parameter int RESULT_W = 10
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // internal side
    asq_link_if.res   link
);
    // word holds the value left-justified, byte holds its top eight bits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            link.res_word <= `ASQ_RES_RESET;
            link.res_high <= `ASQ_RESH_RESET;
        end else if (link.store) begin
            link.res_word <= 16'(link.sar) << `ASQ_RES_SHIFT;
            link.res_high <= link.sar[RESULT_W-1 -: 8];
        end
    end
endmodule
`default_nettype wire

// *** testbench/asq_seq_sva.sv ***
// asq_seq_sva: port checks of the sequencer
// assumes: bound onto asq_sequencer, one clock
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"
module asq_seq_sva #(
    parameter int CHAN_W = 5
) (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   reset_n,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`ASQ_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    // core, trigger, interrupt
    input wire logic                   core_convert_req,
    input wire logic [CHAN_W-1:0]      core_channel,
    input wire logic                   core_abort,
    input wire logic                   core_done,
    input wire logic                   core_in_range,
    input wire logic                   hw_trigger,
    input wire logic                   conversion_done_irq
);
    logic [7:0]        mode_q;
    logic [CHAN_W-1:0] sel_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // shadow of written mode and select
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 8'h00;
            sel_q  <= '0;
        end else if (psel && penable && pwrite) begin
            if (paddr == `ASQ_OFS_MODE) mode_q <= pwdata[7:0];
            if (paddr == `ASQ_OFS_SEL) sel_q <= pwdata[CHAN_W-1:0];
        end
    end
    // committed mode write; trigger clear of bus and launch
    sequence mode_wr_s;
        psel && penable && pwrite && paddr == `ASQ_OFS_MODE;
    endsequence
    sequence trig_s;
        hw_trigger && !(psel && penable) && !core_convert_req;
    endsequence
    req_pulse_a: assert property (core_convert_req |=> !core_convert_req)
        else $error("long request");
    abort_pulse_a: assert property (core_abort |=> !core_abort)
        else $error("long abort");
    irq_cause_a: assert property (conversion_done_irq |-> $past(core_done && core_in_range))
        else $error("stray irq");
    reject_quiet_a: assert property (core_done && !core_in_range |=> !conversion_done_irq)
        else $error("irq on reject");
    sw_launch_a: assert property (mode_wr_s ##0 (pwdata[0] && pwdata[7] && !pwdata[2])
        |=> core_convert_req && core_channel == sel_q)
        else $error("no sw launch");
    no_launch_a: assert property (mode_wr_s ##0 !(pwdata[0] && pwdata[7]) |=> !core_convert_req)
        else $error("bad launch");
    hw_arm_a: assert property (mode_wr_s ##0 (pwdata[0] && pwdata[2] && pwdata[7]
        && !(mode_q[0] && mode_q[2] && mode_q[7])) |=> !core_convert_req)
        else $error("arm launched");
    sw_trig_a: assert property (trig_s ##0 (!mode_q[2] && !core_done) |=> !core_convert_req)
        else $error("sw mode trigger");
    hw_idle_a: assert property (trig_s ##0 (mode_q[2] && !mode_q[7]) |=> !core_convert_req)
        else $error("idle trigger");
    hw_fire_a: assert property (trig_s ##0 (mode_q[0] && mode_q[2] && mode_q[7])
        |=> core_convert_req && core_channel == sel_q)
        else $error("no hw launch");
endmodule
bind asq_sequencer asq_seq_sva #(.CHAN_W(CHAN_W)) u_sva (.*);
`default_nettype wire

// *** testbench/asq_core_model.sv ***
// asq_core_model: behavioural analog core
// assumes: one-cycle request and abort pulses
`timescale 1ns/10ps
`default_nettype none
module asq_core_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // sequencer side
    input  wire logic       core_convert_req,
    input  wire logic [4:0] core_channel,
    input  wire logic       core_abort,
    output logic            core_done,
    output logic [9:0]      core_sar,
    output logic            core_in_range,
    // bench controls
    input  wire logic [3:0] lat,
    input  wire logic       reject
);
    logic       busy;
    logic [3:0] cnt;
    logic [4:0] ch;
    // one conversion per request; a request while busy restarts it
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            ch <= 5'h00;
            core_done <= 1'b0;
            core_sar <= 10'h000;
            core_in_range <= 1'b0;
        end else begin
            core_done <= 1'b0;
            core_sar <= ~core_sar; // garbage outside done
            core_in_range <= ~core_in_range;
            if (core_convert_req) begin
                busy <= 1'b1;
                cnt <= lat;
                ch <= core_channel;
            end else if (core_abort) begin
                busy <= 1'b0;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                core_done <= 1'b1;
                core_sar <= {ch, 5'h0A};
                core_in_range <= ~reject;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top: register tests of the sequencer
// assumes: core model answers each request
`timescale 1ns/10ps
`default_nettype none
`include "asq_params.svh"
module tb_top;
    localparam logic [7:0] MD = `ASQ_OFS_MODE, SL = `ASQ_OFS_SEL, ST = `ASQ_OFS_STAT;
    logic        clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        hw_trigger = 1'b0, reject = 1'b0, pready, pslverr, qe;
    logic        req, abort, done, in_range, irq;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [4:0]  chan;
    logic [9:0]  sar;
    logic [3:0]  lat = 4'h3;
    logic [4:0]  chans[$];
    int          err_total = 0, cmp_count = 0, irq_cnt = 0, ab_cnt = 0, k, i;
    asq_sequencer DUT (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_convert_req(req), .core_channel(chan), .core_abort(abort),
        .core_done(done), .core_sar(sar), .core_in_range(in_range),
        .hw_trigger(hw_trigger), .conversion_done_irq(irq));
    asq_core_model u_core (.clock(clock), .reset_n(reset_n), .core_convert_req(req),
        .core_channel(chan), .core_abort(abort), .core_done(done), .core_sar(sar),
        .core_in_range(in_range), .lat(lat), .reject(reject));
    always #2 clock = ~clock;
    // log launched channels, aborts and interrupts
    always @(posedge clock) begin
        if (req === 1'b1) chans.push_back(chan);
        if (abort === 1'b1) ab_cnt++;
        if (irq === 1'b1) irq_cnt++;
    end
    task results;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, waits for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16) chk("pready", 0, 1);
        q = prdata;
        qe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask
    task st(input logic [2:0] exp);
        apb(1'b0, ST, 32'h0);
        chk("state", q[6:4], exp);
    endtask
    task wait_irq(input int n);
        for (i = 0; i < 3000 && irq_cnt < n; i++) @(posedge clock);
        if (irq_cnt < n) begin
            chk("irq wait", 0, 1);
            results();
        end
    endtask
    task trig;
        @(posedge clock);
        hw_trigger <= 1'b1;
        @(posedge clock);
        hw_trigger <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd(MD, 32'h0, "mode");
        rd(`ASQ_OFS_RES, 32'h0, "word");
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", qe, 1'b1);
        apb(1'b1, MD, 32'h80);
        rd(MD, 32'h0, "start off");
        apb(1'b1, MD, 32'h01);
        st(3'h1);
        repeat (250) @(posedge clock); // settle
        apb(1'b1, SL, 32'h05);
        apb(1'b1, MD, 32'h83);
        wait_irq(1);
        chk("chan", chans[0], 5'h05);
        rd(`ASQ_OFS_RES, {16'h0, 5'h05, 5'h0A, 6'h00}, "word");
        rd(`ASQ_OFS_RESH, {24'h0, 5'h05, 3'h2}, "byte");
        reject <= 1'b1;
        apb(1'b1, MD, 32'h83);
        for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clock);
        if (i == 100) chk("done wait", 0, 1);
        repeat (3) @(posedge clock);
        chk("irq count", irq_cnt, 1);
        rd(`ASQ_OFS_RES, {16'h0, 5'h05, 5'h0A, 6'h00}, "kept word");
        reject <= 1'b0;
        apb(1'b1, SL, 32'h03);
        chans.delete();
        k = irq_cnt;
        apb(1'b1, MD, 32'h8B);
        wait_irq(k + 4);
        for (k = 0; k < 4; k++) chk("scan chan", chans[k], 5'h03 + k);
        rd(MD, 32'h0B, "oneshot end");
        chk("scan count", chans.size(), 4);
        lat <= 4'h9;
        chans.delete();
        k = irq_cnt;
        apb(1'b1, MD, 32'h89);
        wait_irq(k + 5);
        chk("wrap chan", chans[4], 5'h03);
        trig(); // ignored
        k = ab_cnt;
        apb(1'b1, MD, 32'h89);
        repeat (2) @(posedge clock);
        chk("restart chan", chans[$], 5'h03);
        chk("abort", ab_cnt, k + 1);
        apb(1'b1, SL, 32'h0A);
        repeat (2) @(posedge clock);
        chk("select chan", chans[$], 5'h0A);
        apb(1'b1, MD, 32'h09);
        st(3'h1);
        apb(1'b1, MD, 32'h00);
        st(3'h0);
        apb(1'b1, MD, 32'h05);
        apb(1'b1, MD, 32'h85);
        apb(1'b1, MD, 32'h85);
        st(3'h2);
        chans.delete();
        k = irq_cnt;
        trig();
        wait_irq(k + 2);
        chk("hw chan", chans[1], 5'h0A);
        k = ab_cnt;
        trig();
        chk("hw abort", ab_cnt, k + 1);
        apb(1'b1, MD, 32'h05);
        st(3'h1);
        k = chans.size();
        trig();
        chk("idle trigger", chans.size(), k);
        apb(1'b1, MD, 32'h87);
        k = irq_cnt;
        trig();
        wait_irq(k + 1);
        rd(MD, 32'h87, "start kept");
        st(3'h2);
        results();
    end
endmodule
`default_nettype wire
